// [hdl/pic_card_regs.sv]
/*
 * card control and logical device control registers behind an
 * index/data port pair, with per device i/o range check answers.
 * assumes: host strobes come from logic on clk_sys; strap and key
 * detect are pins and pass two flip-flops first.
 */
// What this block does
// - read port write loads address bits 9-2
// - read port register reads have no effect
// - isolation read returns one id bit
// - command register write-only, bits self-clear
// - reset command restores defaults, keeps card number
// - key-wait command enters wait-for-key state
// - number-clear command zeroes card number
// - matching wake leaves sleep to isolate/config
// - wake rewinds the resource byte pointer
// - resource byte read advances the pointer
// - status bit 0 shows resource byte ready
// - card number register readable and writable
// - selector picks the addressed logical device
// - enable and range check hit selected device
// - enable bit 0 activates, bits 7-1 zero
// - range check answers 0055h or 00AAh
// - range check only while device inactive
// - strap low locks pair until key protocol
// - index readback; data port follows index
`timescale 1ns/100ps
module pic_card_regs #(
    parameter int         NUM_DEV   = 4,         // logical devices
    parameter int         RES_LEN   = 8,         // resource bytes
    parameter int         ID_BITS   = 72,        // isolation id length
    parameter logic [71:0] CARD_ID  = 72'h0,     // arbitrary id value
    parameter logic [15:0] IO_SPAN  = 16'h0008   // ports per device
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    input  wire logic                  base_addr_strap_hi, // pin
    input  wire logic                  key_seen,           // pin
    input  wire pic_pkg::pic_host_req_t host_req,
    output logic [7:0]                 host_rdata,
    output logic                       host_rvalid,
    input  wire logic                  io_rd,
    input  wire logic [15:0]           io_addr,
    output logic [15:0]                io_rdata,
    output logic                       io_hit,
    output logic [9:0]                 read_port_addr,
    output logic [NUM_DEV-1:0]         dev_active,
    output pic_pkg::pic_state_t        card_state
);
    import pic_pkg::*;

    // resource bytes, arbitrary contents
    localparam logic [7:0] RES_ROM [RES_LEN] = '{default: 8'h00};
    localparam logic [1:0] RES_CYC = 2'(`PIC_RES_CYC);

    // selector value addresses a real device
    function automatic logic ld_ok(input logic [7:0] sel);
        ld_ok = (32'(sel) < NUM_DEV);
    endfunction

    logic        rst_q1, rst_n;         // reset release pair
    logic        strap_q1, strap_q2;    // strap synchroniser
    logic        key_q1, key_q2;        // key detect synchroniser
    logic        strap_taken;           // strap caught once
    logic        unlocked;              // pair reachable
    logic [7:0]  index_reg;             // index port
    logic [7:0]  card_select_id;        // assigned card number
    logic [7:0]  dev_sel;               // logical device number
    logic [7:0]  rp_bits;               // read port bits 9-2
    logic [2:0]  cmd_pulse;             // one-cycle command actions
    logic [$clog2(RES_LEN)-1:0] res_ptr;   // resource byte pointer
    logic [$clog2(ID_BITS)-1:0] iso_ptr;   // isolation bit pointer
    logic [1:0]  res_wait;              // fetch countdown
    logic        res_ready;             // next byte ready
    logic [7:0]  res_data;              // fetched byte
    logic [NUM_DEV-1:0] dev_en;         // activation bits
    logic [NUM_DEV-1:0] chk_en;         // range check enables
    logic [NUM_DEV-1:0] chk_pat;        // pattern selects
    logic [15:0] io_base [NUM_DEV];     // per device i/o bases
    logic [NUM_DEV-1:0] dev_hit;        // per device range hit

    // access decode
    wire       acc_ok   = unlocked;
    wire       idx_wr   = host_req.wr & ~host_req.sel_data & acc_ok;
    wire       dat_wr   = host_req.wr & host_req.sel_data & acc_ok;
    wire       dat_rd   = host_req.rd & host_req.sel_data & acc_ok;
    wire       in_cfg   = (card_state == PIC_CONFIG);
    wire       sel_ok   = ld_ok(dev_sel);
    wire [1:0] sel_i    = dev_sel[1:0];
    wire       wr_rp    = dat_wr & (index_reg == `PIC_IDX_READ_PORT);
    wire       wr_cmd   = dat_wr & (index_reg == `PIC_IDX_CARD_CMD);
    wire       wr_wake  = dat_wr & (index_reg == `PIC_IDX_WAKE);
    wire       wr_num   = dat_wr & (index_reg == `PIC_IDX_CARD_NUM)
                          & (in_cfg | card_state == PIC_ISOLATE);
    wire       wr_sel   = dat_wr & in_cfg & (index_reg == `PIC_IDX_DEV_SEL);
    wire       wr_dev   = dat_wr & in_cfg & sel_ok;
    wire       rd_iso   = dat_rd & (index_reg == `PIC_IDX_ISO_READ)
                          & (card_state == PIC_ISOLATE);
    wire       rd_res   = dat_rd & (index_reg == `PIC_IDX_RES_BYTE) & res_ready;
    wire       wake_hit = wr_wake & (card_state == PIC_SLEEP)
                          & (host_req.wdata == card_select_id);
    wire       soft_rst = cmd_pulse[`PIC_CMD_RESET];

    // reset release through two flip-flops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // pin synchronisers; first stage read by second only
    // no reset here: the strap has crossed by the time the internal
    // reset lets go, so the first edge after release sees its real level
    always_ff @(posedge clk_sys) begin
        strap_q1 <= base_addr_strap_hi;
        strap_q2 <= strap_q1;
        key_q1   <= key_seen;
        key_q2   <= key_q1;
    end

    // strap caught at release; low strap keeps the pair locked
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strap_taken <= 1'b0;
            unlocked    <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            unlocked    <= strap_q2;
        end else if (key_q2) begin
            unlocked    <= 1'b1;
        end
    end

    // state machine; a high strap wakes straight into config
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            card_state <= PIC_WAIT_KEY;
        end else begin
            case (card_state)
                PIC_WAIT_KEY: begin
                    if (!strap_taken && strap_q2)
                        card_state <= PIC_CONFIG;
                    else if (key_q2)
                        card_state <= PIC_SLEEP;
                end
                PIC_SLEEP: begin
                    if (wake_hit)
                        card_state <= (host_req.wdata == `PIC_ZERO8) ?
                                      PIC_ISOLATE : PIC_CONFIG;
                end
                PIC_ISOLATE, PIC_CONFIG: begin
                    if (wr_wake && !wake_hit)
                        card_state <= PIC_SLEEP;
                end
                default: card_state <= PIC_WAIT_KEY;
            endcase
            if (cmd_pulse[`PIC_CMD_KEY_WAIT])
                card_state <= PIC_WAIT_KEY;
        end
    end

    // command bits live one cycle only; never read back
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            cmd_pulse <= 3'h0;
        else
            cmd_pulse <= wr_cmd ? host_req.wdata[2:0] : 3'h0;
    end

    // index port and card level registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            index_reg      <= `PIC_ZERO8;
            card_select_id <= `PIC_ZERO8;
            dev_sel        <= `PIC_ZERO8;
            rp_bits        <= `PIC_ZERO8;
        end else begin
            if (idx_wr)
                index_reg <= host_req.wdata;
            if (cmd_pulse[`PIC_CMD_CSN_CLR])
                card_select_id <= `PIC_ZERO8;
            else if (wr_num)
                card_select_id <= host_req.wdata;
            // soft reset keeps the card number
            if (soft_rst) begin
                dev_sel <= `PIC_ZERO8;
                rp_bits <= `PIC_ZERO8;
            end else begin
                if (wr_sel)
                    dev_sel <= host_req.wdata;
                if (wr_rp)
                    rp_bits <= host_req.wdata;
            end
        end
    end
    assign read_port_addr = {rp_bits, `PIC_RP_LOW};

    // resource pointer and ready flag; wake rewinds
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            res_ptr   <= '0;
            res_ready <= 1'b0;
            res_wait  <= RES_CYC;
            res_data  <= `PIC_ZERO8;
        end else if (wr_wake) begin
            res_ptr   <= '0;
            res_ready <= 1'b0;
            res_wait  <= RES_CYC;
        end else if (rd_res) begin
            res_ptr   <= res_ptr + 1'b1;
            res_ready <= 1'b0;
            res_wait  <= RES_CYC;
        end else if (!res_ready) begin
            // fetch latency models the serial source
            if (res_wait == 2'h0) begin
                res_data  <= RES_ROM[res_ptr];
                res_ready <= 1'b1;
            end else begin
                res_wait  <= res_wait - 2'h1;
            end
        end
    end

    // isolation pointer walks the id one bit per read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            iso_ptr <= '0;
        else if (card_state != PIC_ISOLATE)
            iso_ptr <= '0;
        else if (rd_iso && 32'(iso_ptr) < ID_BITS - 1)
            iso_ptr <= iso_ptr + 1'b1;
    end

    // per device control registers and range decode
    genvar g;
    generate
        for (g = 0; g < NUM_DEV; g++) begin : g_dev
            wire here = wr_dev & (32'(sel_i) == g);
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    dev_en[g]  <= 1'b0;
                    chk_en[g]  <= 1'b0;
                    chk_pat[g] <= 1'b0;
                    io_base[g] <= `PIC_ZERO16;
                end else if (soft_rst) begin
                    dev_en[g]  <= 1'b0;
                    chk_en[g]  <= 1'b0;
                    chk_pat[g] <= 1'b0;
                    io_base[g] <= `PIC_ZERO16;
                end else if (here) begin
                    if (index_reg == `PIC_IDX_DEV_EN)
                        dev_en[g] <= host_req.wdata[`PIC_EN_BIT];
                    if (index_reg == `PIC_IDX_CHK_CTRL) begin
                        chk_en[g]  <= host_req.wdata[`PIC_CHK_EN_BIT];
                        chk_pat[g] <= host_req.wdata[`PIC_CHK_PAT_BIT];
                    end
                    if (index_reg == `PIC_IDX_IO_BASE_HI)
                        io_base[g][15:8] <= host_req.wdata;
                    if (index_reg == `PIC_IDX_IO_BASE_LO)
                        io_base[g][7:0] <= host_req.wdata;
                end
            end
            // check only counts while the device is inactive
            assign dev_hit[g] = chk_en[g] & ~dev_en[g]
                                & (io_addr >= io_base[g])
                                & (io_addr - io_base[g] < IO_SPAN);
        end
    endgenerate
    assign dev_active = dev_en;

    // lowest hit device answers the range check read
    logic [15:0] next_io_rdata;
    always_comb begin
        next_io_rdata = `PIC_ZERO16;
        for (int i = NUM_DEV - 1; i >= 0; i--)
            if (dev_hit[i])
                next_io_rdata = chk_pat[i] ? `PIC_PAT_ONE : `PIC_PAT_ZERO;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata <= `PIC_ZERO16;
            io_hit   <= 1'b0;
        end else begin
            io_hit   <= io_rd & (|dev_hit);
            io_rdata <= (io_rd & (|dev_hit)) ? next_io_rdata : `PIC_ZERO16;
        end
    end

    // data port read selection; write-only registers read zero
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = `PIC_ZERO8;
        case (index_reg)
            `PIC_IDX_ISO_READ:
                next_rdata = CARD_ID[iso_ptr] ? `PIC_ISO_ONE : `PIC_ISO_ZERO;
            `PIC_IDX_RES_BYTE: next_rdata = res_data;
            `PIC_IDX_RES_FLAG: next_rdata = {7'h00, res_ready};
            `PIC_IDX_CARD_NUM: next_rdata = card_select_id;
            `PIC_IDX_DEV_SEL:  next_rdata = dev_sel;
            `PIC_IDX_DEV_EN:
                next_rdata = sel_ok ? {7'h00, dev_en[sel_i]} : `PIC_ZERO8;
            `PIC_IDX_CHK_CTRL:
                next_rdata = sel_ok ? {6'h00, chk_en[sel_i], chk_pat[sel_i]}
                                    : `PIC_ZERO8;
            `PIC_IDX_IO_BASE_HI:
                next_rdata = sel_ok ? io_base[sel_i][15:8] : `PIC_ZERO8;
            `PIC_IDX_IO_BASE_LO:
                next_rdata = sel_ok ? io_base[sel_i][7:0] : `PIC_ZERO8;
            default: next_rdata = `PIC_ZERO8;
        endcase
    end

    // read answers one cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata  <= `PIC_ZERO8;
            host_rvalid <= 1'b0;
        end else begin
            host_rvalid <= host_req.rd & acc_ok;
            if (host_req.rd & acc_ok)
                host_rdata <= host_req.sel_data ? next_rdata : index_reg;
        end
    end

    // checks
    property p_rp_load;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_rp && !soft_rst |=> read_port_addr == {$past(host_req.wdata), 2'h3};
    endproperty
    a_rp_load: assert property (p_rp_load) else $error("read port wrong");
    property p_cmd_pulse;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_cmd |=> ##1 (cmd_pulse == 3'h0 || $past(wr_cmd));
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("cmd stuck");
    property p_key_wait;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_cmd && host_req.wdata[1] |=> ##1 card_state == PIC_WAIT_KEY;
    endproperty
    a_key_wait: assert property (p_key_wait) else $error("no key wait");
    property p_csn_clr;
        @(posedge clk_sys) disable iff (!rst_n)
        cmd_pulse[2] |=> card_select_id == 8'h00;
    endproperty
    a_csn_clr: assert property (p_csn_clr) else $error("csn kept");
    property p_wake;
        @(posedge clk_sys) disable iff (!rst_n)
        wake_hit && host_req.wdata != 8'h00 && !cmd_pulse[1]
        |=> card_state == PIC_CONFIG;
    endproperty
    a_wake: assert property (p_wake) else $error("wake missed");
    property p_rewind;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_wake |=> res_ptr == 0 && !res_ready ##[1:4] res_ready;
    endproperty
    a_rewind: assert property (p_rewind) else $error("no rewind");
    property p_ready;
        @(posedge clk_sys) disable iff (!rst_n)
        rd_res && !wr_wake |=> !res_ready && res_ptr == $past(res_ptr) + 1'b1;
    endproperty
    a_ready: assert property (p_ready) else $error("ptr stuck");
    property p_range;
        @(posedge clk_sys) disable iff (!rst_n)
        io_rd && dev_hit[0] |=> io_hit && io_rdata == ($past(chk_pat[0]) ?
                                16'h0055 : 16'h00AA);
    endproperty
    a_range: assert property (p_range) else $error("range answer");
    property p_inactive;
        @(posedge clk_sys) disable iff (!rst_n)
        io_rd && ((chk_en & ~dev_en) == '0) |=> !io_hit;
    endproperty
    a_inactive: assert property (p_inactive) else $error("active hit");
    c_wake_iso: cover property (@(posedge clk_sys) wake_hit && host_req.wdata == 8'h00);
    c_res_read: cover property (@(posedge clk_sys) rd_res);
    c_range:    cover property (@(posedge clk_sys) io_hit);
endmodule // pic_card_regs

// [hdl/pic_cfg.svh]
/*
 * register offsets, field positions, patterns and timing counts
 * of the card control register bank.
 * assumes: included by the package only; the design module uses its macros.
 */
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH
// card level register indices
`define PIC_IDX_READ_PORT   8'h00
`define PIC_IDX_ISO_READ    8'h01
`define PIC_IDX_CARD_CMD    8'h02
`define PIC_IDX_WAKE        8'h03
`define PIC_IDX_RES_BYTE    8'h04
`define PIC_IDX_RES_FLAG    8'h05
`define PIC_IDX_CARD_NUM    8'h06
`define PIC_IDX_DEV_SEL     8'h07
// per logical device indices
`define PIC_IDX_DEV_EN      8'h30
`define PIC_IDX_CHK_CTRL    8'h31
`define PIC_IDX_IO_BASE_HI  8'h60
`define PIC_IDX_IO_BASE_LO  8'h61
// command and field bits
`define PIC_CMD_RESET       0
`define PIC_CMD_KEY_WAIT    1
`define PIC_CMD_CSN_CLR     2
`define PIC_EN_BIT          0
`define PIC_CHK_PAT_BIT     0
`define PIC_CHK_EN_BIT      1
// fixed read port low bits and answer patterns
`define PIC_RP_LOW          2'h3
`define PIC_PAT_ONE         16'h0055
`define PIC_PAT_ZERO        16'h00AA
`define PIC_ISO_ONE         8'h55
`define PIC_ISO_ZERO        8'hAA
`define PIC_ZERO8           8'h00
`define PIC_ZERO16          16'h0000
// resource byte fetch latency in ns and in cycles at 100 MHz
`define PIC_CLK_NS          10
`define PIC_RES_NS          20
`define PIC_RES_CYC         ((`PIC_RES_NS + `PIC_CLK_NS - 1) / `PIC_CLK_NS)
`endif

// [hdl/pic_pkg.sv]
/*
 * types shared by the card control register bank.
 * assumes: pic_cfg.svh sits beside it on the include path.
 */
package pic_pkg;
    `include "pic_cfg.svh"
    // card protocol states
    typedef enum logic [1:0] {
        PIC_WAIT_KEY,
        PIC_SLEEP,
        PIC_ISOLATE,
        PIC_CONFIG
    } pic_state_t;
    // one host access to the index/data pair
    typedef struct packed {
        logic       wr;       // write strobe, one cycle
        logic       rd;       // read strobe, one cycle
        logic       sel_data; // 0 index port, 1 data port
        logic [7:0] wdata;    // write data
    } pic_host_req_t;
endpackage

// [test/pic_host_model.sv]
/* isa host model: index/data pair accesses and io reads for the card bank.
   assumes: shares clk_sys with the card; drives everything at falling edges. */
`timescale 1ns/100ps
module pic_host_model
    import pic_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   host_rvalid,
    input  wire logic [7:0]             host_rdata,
    input  wire logic                   io_hit,
    input  wire logic [15:0]            io_rdata,
    output pic_pkg::pic_host_req_t      host_req,
    output logic                        io_rd,
    output logic [15:0]                 io_addr
);
    // idle bus until the first access
    initial begin
        host_req = '0;
        io_rd    = 1'b0;
        io_addr  = 16'h0000;
    end
    // one write strobe; data inverted once released so stale values never match
    task put(input logic sel, input logic [7:0] d);
        @(negedge clk_sys) host_req = '{1'b1, 1'b0, sel, d};
        @(negedge clk_sys) host_req = '{1'b0, 1'b0, sel, ~d};
    endtask
    // one read strobe, answer awaited for a few cycles only
    task get(input logic sel, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d  = 8'h00;
        @(negedge clk_sys) host_req = '{1'b0, 1'b1, sel, 8'h00};
        @(negedge clk_sys) host_req.rd = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (host_rvalid === 1'b1) begin
                ok = 1'b1;
                d  = host_rdata;
            end else @(negedge clk_sys);
        end
    endtask
    // status poll before a resource byte read, bounded
    task poll(output logic ok);
        logic [7:0] s;
        logic       v;
        ok = 1'b0;
        put(1'b0, 8'h05);
        for (int i = 0; i < 10 && !ok; i++) begin
            get(1'b1, s, v);
            ok = v & s[0];
        end
    endtask
    // one io read strobe; hit looked for in the two cycles after it
    task io_get(input logic [15:0] a, output logic hit, output logic [15:0] d);
        @(negedge clk_sys) begin
            io_rd   = 1'b1;
            io_addr = a;
        end
        @(negedge clk_sys) begin
            io_rd   = 1'b0;
            io_addr = ~a;
        end
        hit = io_hit;
        d   = io_rdata;
        if (hit !== 1'b1) begin
            @(negedge clk_sys);
            hit = io_hit;
            d   = io_rdata;
        end
    endtask
endmodule // pic_host_model

// [test/pic_card_regs_tb.sv]
/* self-checking bench for the card control register bank.
   assumes: strap high from the first reset so the pair is open;
   the last test resets again with the strap low. */
`timescale 1ns/100ps
module pic_card_regs_tb;
    import pic_pkg::*;
    logic clk_sys, rst_b, strap, key_seen, host_rvalid, io_rd, io_hit, ok, hit;
    pic_host_req_t host_req;
    logic [7:0]    host_rdata, v;
    logic [15:0]   io_addr, io_rdata, d;
    logic [9:0]    read_port_addr;
    logic [3:0]    dev_active;
    pic_state_t    card_state;
    int            err_count = 0;
    int            checks_done = 0;
    // clock and pins
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;
    initial begin
        rst_b = 1'b0;
        strap = 1'b1;
        key_seen = 1'b0;
    end
    pic_card_regs u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .base_addr_strap_hi(strap),
        .key_seen(key_seen), .host_req(host_req), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .io_rd(io_rd), .io_addr(io_addr), .io_rdata(io_rdata),
        .io_hit(io_hit), .read_port_addr(read_port_addr), .dev_active(dev_active),
        .card_state(card_state));
    pic_host_model u_host (.clk_sys(clk_sys), .host_rvalid(host_rvalid),
        .host_rdata(host_rdata), .io_hit(io_hit), .io_rdata(io_rdata),
        .host_req(host_req), .io_rd(io_rd), .io_addr(io_addr));
    // compare and count
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wreg(input logic [7:0] idx, input logic [7:0] val);
        u_host.put(1'b0, idx);
        u_host.put(1'b1, val);
    endtask
    task rreg(input logic [7:0] idx, output logic [7:0] val);
        u_host.put(1'b0, idx);
        u_host.get(1'b1, val, ok);
        chk("rvalid", 16'h0001, {15'h0, ok});
    endtask
    task settle;
        repeat (3) @(negedge clk_sys);
    endtask
    // index readback and selector
    task t_index;
        chk("state", {14'h0, PIC_CONFIG}, {14'h0, card_state});
        chk("rp_rst", 16'h0003, {6'h0, read_port_addr});
        wreg(8'h07, 8'h02);
        u_host.get(1'b0, v, ok);
        chk("index", 16'h0007, {8'h0, v});
        rreg(8'h07, v);
        chk("dev_sel", 16'h0002, {8'h0, v});
        $display("t_index done");
    endtask
    // read port and write-only readback
    task t_read_port;
        wreg(8'h00, 8'hA5);
        chk("rp_addr", 16'h0297, {6'h0, read_port_addr});
        rreg(8'h00, v);
        chk("rp_read", 16'h0000, {8'h0, v});
        $display("t_read_port done");
    endtask
    // card number write, clear command
    task t_csn;
        wreg(8'h06, 8'h03);
        rreg(8'h06, v);
        chk("csn", 16'h0003, {8'h0, v});
        wreg(8'h02, 8'h04);
        settle();
        rreg(8'h06, v);
        chk("csn_clr", 16'h0000, {8'h0, v});
        rreg(8'h02, v);
        chk("cmd_read", 16'h0000, {8'h0, v});
        $display("t_csn done");
    endtask
    // range check answers, span edge, activation
    task t_range;
        wreg(8'h07, 8'h01);
        wreg(8'h60, 8'h02);
        wreg(8'h61, 8'h00);
        wreg(8'h31, 8'h03);
        rreg(8'h31, v);
        chk("chk_rd", 16'h0003, {8'h0, v});
        u_host.io_get(16'h0207, hit, d);
        chk("pat1", 16'h0055, hit ? d : 16'hFFFF);
        u_host.io_get(16'h0208, hit, d);
        chk("span", 16'h0000, {15'h0, hit});
        wreg(8'h31, 8'h02);
        u_host.io_get(16'h0200, hit, d);
        chk("pat0", 16'h00AA, hit ? d : 16'hFFFF);
        wreg(8'h31, 8'h00);
        wreg(8'h30, 8'h01);
        chk("active", 16'h0002, {12'h0, dev_active});
        rreg(8'h30, v);
        chk("act_rd", 16'h0001, {8'h0, v});
        wreg(8'h31, 8'h03);
        u_host.io_get(16'h0200, hit, d);
        chk("act_chk", 16'h0000, {15'h0, hit});
        wreg(8'h31, 8'h00);
        wreg(8'h07, 8'h00);
        wreg(8'h31, 8'h03);
        u_host.io_get(16'h0005, hit, d);
        chk("pat_dev0", 16'h0055, hit ? d : 16'hFFFF);
        wreg(8'h31, 8'h00);
        wreg(8'h07, 8'h01);
        $display("t_range done");
    endtask
    // resource ready polling
    task t_res;
        u_host.poll(ok);
        chk("ready", 16'h0001, {15'h0, ok});
        rreg(8'h04, v);
        chk("res", 16'h0000, {8'h0, v});
        u_host.poll(ok);
        chk("ready2", 16'h0001, {15'h0, ok});
        $display("t_res done");
    endtask
    // key wait, wake to isolate, isolation read, wake to config
    task t_state;
        wreg(8'h02, 8'h02);
        settle();
        chk("keywait", {14'h0, PIC_WAIT_KEY}, {14'h0, card_state});
        chk("keep_act", 16'h0002, {12'h0, dev_active});
        key_seen = 1'b1;
        repeat (4) @(negedge clk_sys);
        key_seen = 1'b0;
        chk("sleep", {14'h0, PIC_SLEEP}, {14'h0, card_state});
        wreg(8'h03, 8'h00);
        settle();
        chk("isolate", {14'h0, PIC_ISOLATE}, {14'h0, card_state});
        rreg(8'h01, v);
        chk("iso_bit", 16'h00AA, {8'h0, v});
        wreg(8'h06, 8'h05);
        wreg(8'h03, 8'h09);
        settle();
        chk("nomatch", {14'h0, PIC_SLEEP}, {14'h0, card_state});
        wreg(8'h03, 8'h05);
        settle();
        chk("config", {14'h0, PIC_CONFIG}, {14'h0, card_state});
        $display("t_state done");
    endtask
    // soft reset keeps card number
    task t_soft;
        wreg(8'h02, 8'h01);
        settle();
        chk("soft_act", 16'h0000, {12'h0, dev_active});
        chk("soft_rp", 16'h0003, {6'h0, read_port_addr});
        rreg(8'h06, v);
        chk("soft_csn", 16'h0005, {8'h0, v});
        rreg(8'h07, v);
        chk("soft_sel", 16'h0000, {8'h0, v});
        $display("t_soft done");
    endtask
    // strap low keeps the pair locked until the key is seen
    task t_lock;
        rst_b = 1'b0;
        strap = 1'b0;
        repeat (5) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk("lk_state", {14'h0, PIC_WAIT_KEY}, {14'h0, card_state});
        u_host.get(1'b0, v, ok);
        chk("locked", 16'h0000, {15'h0, ok});
        key_seen = 1'b1;
        repeat (4) @(negedge clk_sys);
        u_host.get(1'b0, v, ok);
        chk("unlocked", 16'h0001, {15'h0, ok});
        $display("t_lock done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys) rst_b = 1'b1;
        repeat (8) @(negedge clk_sys);
        t_index();
        t_read_port();
        t_csn();
        t_range();
        t_res();
        t_state();
        t_soft();
        t_lock();
        stop_test();
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
endmodule // pic_card_regs_tb
